// ===== shared/scm_pkg.sv
// Purpose: shared constants, types and arithmetic helpers of the sensor correction math
// Assumes: all coefficients are 16-bit codes loaded from configuration storage
// Notes:   intermediates are signed 32-bit and saturate instead of wrapping
package scm_pkg;

  // widths
  localparam int RAWC_W = 16;
  localparam int RAWT_W = 14;
  localparam int COEF_W = 16;
  localparam int ACC_W  = 32;
  localparam int DVD_W  = 48;
  localparam int CNT_W  = 6;

  // fixed-point scaling
  localparam int TC_SH   = 15;  // drift coefficients per raw temperature code
  localparam int DEN_SH  = 15;  // denominator fraction bits
  localparam int GAIN_SH = 12;  // gain coefficients
  localparam int SQ_SH   = 16;  // square and cube normalised to full scale
  localparam int COEF_SH = 15;  // quadratic and cubic coefficients
  localparam int T1_SH   = 14;  // temperature gain
  localparam int T2_SH   = 28;  // temperature quadratic term

  // constants
  localparam logic signed [31:0] DEN_ONE    = 32'sh0000_8000;
  localparam logic signed [31:0] HALF_SCALE = 32'sh0000_8000;
  localparam logic signed [31:0] CAP_MAX    = 32'sh0000_FFFF;
  localparam logic signed [31:0] TEMP_MAX   = 32'sh0000_7FFF;
  localparam logic signed [31:0] TEMP_MIN   = -32'sh0000_8000;
  localparam logic [RAWT_W-1:0]  RAWT_FULL  = 14'h3FFF;
  localparam logic [2:0]         RES_MAX_SH = 3'h6;
  localparam logic [CNT_W-1:0]   DIV_STEPS  = 6'h30;

  // capacitance correction modes
  typedef enum logic {
    SCM_MODE_TWO_REGION,
    SCM_MODE_CUBIC
  } scm_mode_t;

  // calibration coefficient set
  typedef struct packed {
    logic [COEF_W-1:0] offset;
    logic [COEF_W-1:0] gain_one;
    logic [COEF_W-1:0] gain_two;
    logic [COEF_W-1:0] region_one_quadratic;
    logic [COEF_W-1:0] region_two_quadratic;  // cubic_coefficient in cubic mode
    logic [COEF_W-1:0] offset_drift;
    logic [COEF_W-1:0] offset_drift_quadratic;
    logic [COEF_W-1:0] gain_drift;
    logic [COEF_W-1:0] gain_drift_quadratic;
    logic [COEF_W-1:0] temp_reference;        // raw temperature code, low 14 bits
    logic [COEF_W-1:0] break_point;           // unsigned raw code
    logic [COEF_W-1:0] temperature_gain;
    logic [COEF_W-1:0] temperature_offset;
    logic [COEF_W-1:0] temperature_quadratic_coef;
  } scm_coef_t;

  // result flags
  typedef struct packed {
    logic div_err;
    logic sat;
  } scm_flags_t;

  // clamp a wide signed value to 32 bits
  function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_7FFF_FFFF) begin
      return 32'sh7FFF_FFFF;
    end else if (v < -64'sh0000_0000_8000_0000) begin
      return -32'sh8000_0000;
    end
    return v[31:0];
  endfunction

  // saturating product with arithmetic scaling
  function automatic logic signed [31:0] mulsh(input logic signed [31:0] a,
                                               input logic signed [31:0] b,
                                               input int sh);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    return sat32(p >>> sh);
  endfunction

  // saturating sum
  function automatic logic signed [31:0] addsat(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
    return sat32(64'(a) + 64'(b));
  endfunction

  // sign-extend a 16-bit coefficient
  function automatic logic signed [31:0] sx16(input logic [COEF_W-1:0] c);
    return 32'(signed'(c));
  endfunction

endpackage

// ===== src/scm_divider.sv
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: divisor is non-zero when start_i is pulsed
// Notes:   done_o pulses in the same cycle that the last quotient bit appears
`timescale 1ns/1ns
module scm_divider (
  // clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_b_i,
  // request
  input  wire logic                       start_i,
  input  wire logic [scm_pkg::DVD_W-1:0]  dividend_i,
  input  wire logic [scm_pkg::ACC_W-1:0]  divisor_i,
  // answer
  output logic                            done_o,
  output logic [scm_pkg::DVD_W-1:0]       quotient_o
);

  logic [scm_pkg::ACC_W:0]   rem_ff;
  logic [scm_pkg::DVD_W-1:0] quo_ff;
  logic [scm_pkg::ACC_W-1:0] div_ff;
  logic [scm_pkg::CNT_W-1:0] cnt_ff;
  logic                      run_ff;
  logic                      done_ff;

  // one restoring step
  wire logic [scm_pkg::ACC_W:0] rem_sh  = {rem_ff[scm_pkg::ACC_W-1:0], quo_ff[scm_pkg::DVD_W-1]};
  wire logic                    fits    = rem_sh >= {1'b0, div_ff};
  wire logic [scm_pkg::ACC_W:0] rem_sub = rem_sh - {1'b0, div_ff};
  wire logic                    last    = cnt_ff == scm_pkg::DIV_STEPS - 6'h01;

  // iteration state
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      div_ff  <= '0;
      cnt_ff  <= '0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= run_ff && last;
      if (start_i) begin
        rem_ff <= '0;
        quo_ff <= dividend_i;
        div_ff <= divisor_i;
        cnt_ff <= '0;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        rem_ff <= fits ? rem_sub : rem_sh;
        quo_ff <= {quo_ff[scm_pkg::DVD_W-2:0], fits};
        cnt_ff <= cnt_ff + 6'h01;
        run_ff <= !last;
      end
    end
  end

  assign done_o     = done_ff;
  assign quotient_o = quo_ff;

endmodule // scm_divider

// ===== src/scm_core.sv
// Purpose: temperature-compensated capacitance and corrected temperature datapath
// Assumes: inputs and coefficients are steady when start_i is pulsed while idle
// Notes:   multi-cycle; one result per start, valid_o pulses when cap_o and flags update, temp_o updates earlier in the run
`timescale 1ns/1ns
module scm_core (
  // clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_b_i,
  // request
  input  wire logic                        start_i,
  input  wire logic [scm_pkg::RAWC_W-1:0]  raw_c_i,
  input  wire logic [scm_pkg::RAWT_W-1:0]  raw_t_i,
  input  wire scm_pkg::scm_mode_t          mode_i,
  input  wire logic [1:0]                  temp_res_i,
  input  wire scm_pkg::scm_coef_t          coef_i,
  // results
  output logic [scm_pkg::RAWC_W-1:0]       cap_o,
  output logic [15:0]                      temp_o,
  output logic                             valid_o,
  output logic                             busy_o,
  output logic                             div_err_o,
  output logic                             sat_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_TC1, S_TC2, S_DIV, S_SPLIT, S_GAIN, S_SQ, S_CUBE, S_SUM
  } scm_state_t;

  scm_state_t          state_ff;
  scm_pkg::scm_coef_t  coef_ff;
  scm_pkg::scm_mode_t  mode_ff;
  scm_pkg::scm_flags_t flags_ff;
  logic signed [31:0]  rawt_ff, dt_ff, x_ff, odr_ff, gdr_ff, tsq_ff;
  logic signed [31:0]  num_ff, den_ff, temp_corrected_raw_ff, r1_ff, r2_ff;
  logic signed [31:0]  u1_ff, u2_ff, sq1_ff, sq2_ff, cube_ff;
  logic                num_neg_ff;
  logic [15:0]         cap_ff, temp_ff;
  logic                valid_ff, busy_ff, div_err_ff, sat_ff;
  logic                div_start_ff;
  logic                div_done;
  logic [scm_pkg::DVD_W-1:0] div_q;

  // coefficients widened to signed 32 bits
  wire logic signed [31:0] k_off  = scm_pkg::sx16(coef_ff.offset);
  wire logic signed [31:0] k_g1   = scm_pkg::sx16(coef_ff.gain_one);
  wire logic signed [31:0] k_g2   = scm_pkg::sx16(coef_ff.gain_two);
  wire logic signed [31:0] k_q1   = scm_pkg::sx16(coef_ff.region_one_quadratic);
  wire logic signed [31:0] k_q2   = scm_pkg::sx16(coef_ff.region_two_quadratic);
  wire logic signed [31:0] k_tco  = scm_pkg::sx16(coef_ff.offset_drift);
  wire logic signed [31:0] k_sco  = scm_pkg::sx16(coef_ff.offset_drift_quadratic);
  wire logic signed [31:0] k_tcg  = scm_pkg::sx16(coef_ff.gain_drift);
  wire logic signed [31:0] k_scg  = scm_pkg::sx16(coef_ff.gain_drift_quadratic);
  wire logic signed [31:0] k_tg   = scm_pkg::sx16(coef_ff.temperature_gain);
  wire logic signed [31:0] k_to   = scm_pkg::sx16(coef_ff.temperature_offset);
  wire logic signed [31:0] k_tq   = scm_pkg::sx16(coef_ff.temperature_quadratic_coef);
  wire logic signed [31:0] k_brk  = 32'(coef_ff.break_point);

  // resolution mask keeps the low 8, 10, 12 or 14 bits of the raw temperature
  wire logic [2:0]          res_sh  = scm_pkg::RES_MAX_SH - {temp_res_i, 1'b0};
  wire logic [13:0]         res_msk = scm_pkg::RAWT_FULL >> res_sh;
  wire logic [13:0]         rawt_in = raw_t_i & res_msk;

  // drift terms: inner brackets, then numerator and denominator
  wire logic signed [31:0] odr_n = scm_pkg::addsat(k_tco,
                                   scm_pkg::mulsh(dt_ff, k_sco, scm_pkg::TC_SH));
  wire logic signed [31:0] gdr_n = scm_pkg::addsat(k_tcg,
                                   scm_pkg::mulsh(dt_ff, k_scg, scm_pkg::TC_SH));
  wire logic signed [31:0] num_n = scm_pkg::addsat(scm_pkg::addsat(x_ff, k_off),
                                   scm_pkg::mulsh(dt_ff, odr_ff, scm_pkg::TC_SH));
  wire logic signed [31:0] den_n = scm_pkg::addsat(scm_pkg::DEN_ONE,
                                   scm_pkg::mulsh(dt_ff, gdr_ff, scm_pkg::TC_SH));

  // corrected temperature before clamping
  wire logic signed [31:0] temp_n = scm_pkg::addsat(scm_pkg::addsat(
                                    scm_pkg::mulsh(k_tq, tsq_ff, scm_pkg::T2_SH),
                                    scm_pkg::mulsh(k_tg, rawt_ff, scm_pkg::T1_SH)), k_to);
  wire logic t_hi = temp_n > scm_pkg::TEMP_MAX;
  wire logic t_lo = temp_n < scm_pkg::TEMP_MIN;
  wire logic [15:0] temp_c = t_hi ? 16'h7FFF : (t_lo ? 16'h8000 : temp_n[15:0]);

  // divider operands and signed quotient
  wire logic [31:0] num_mag = num_ff[31] ? 32'(-num_ff) : 32'(num_ff);
  wire logic [scm_pkg::DVD_W-1:0] dvd = {num_mag, 16'h0000} >> (16 - scm_pkg::DEN_SH);
  wire logic q_big = |div_q[scm_pkg::DVD_W-1:31];
  wire logic signed [31:0] q_mag = q_big ? 32'sh7FFF_FFFF : signed'(div_q[31:0]);
  wire logic signed [31:0] q_sgn = num_neg_ff ? -q_mag : q_mag;
  wire logic signed [31:0] rtc_n = scm_pkg::addsat(q_sgn, scm_pkg::HALF_SCALE);
  wire logic rtc_hi = rtc_n > scm_pkg::CAP_MAX;
  wire logic rtc_lo = rtc_n < 32'sh0;
  wire logic signed [31:0] rtc_c = rtc_hi ? scm_pkg::CAP_MAX : (rtc_lo ? 32'sh0 : rtc_n);

  // region split
  wire logic two_reg = mode_ff == scm_pkg::SCM_MODE_TWO_REGION;
  wire logic signed [31:0] r1_n = (two_reg && temp_corrected_raw_ff > k_brk) ? k_brk : temp_corrected_raw_ff;
  wire logic signed [31:0] r2_d = temp_corrected_raw_ff - k_brk;
  wire logic signed [31:0] r2_n = (two_reg && !r2_d[31]) ? r2_d : 32'sh0;

  // final polynomial
  wire logic signed [31:0] reg1_t = scm_pkg::addsat(u1_ff,
                                    scm_pkg::mulsh(k_q1, sq1_ff, scm_pkg::COEF_SH));
  wire logic signed [31:0] reg2_t = scm_pkg::addsat(u2_ff,
                                    scm_pkg::mulsh(k_q2, sq2_ff, scm_pkg::COEF_SH));
  wire logic signed [31:0] cub_t  = scm_pkg::mulsh(k_q2, cube_ff, scm_pkg::COEF_SH);
  wire logic signed [31:0] out_n  = scm_pkg::addsat(reg1_t, two_reg ? reg2_t : cub_t);
  wire logic out_hi = out_n > scm_pkg::CAP_MAX;
  wire logic out_lo = out_n < 32'sh0;
  wire logic [15:0] out_c = out_hi ? 16'hFFFF : (out_lo ? 16'h0000 : out_n[15:0]);

  // sequencing and datapath registers
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= S_IDLE;
      coef_ff <= '0;
      mode_ff <= scm_pkg::SCM_MODE_TWO_REGION;
      flags_ff <= '0;
      {rawt_ff, dt_ff, x_ff, odr_ff, gdr_ff, tsq_ff} <= '0;
      {num_ff, den_ff, temp_corrected_raw_ff, r1_ff, r2_ff} <= '0;
      {u1_ff, u2_ff, sq1_ff, sq2_ff, cube_ff} <= '0;
      num_neg_ff <= 1'b0;
      cap_ff <= '0;
      temp_ff <= '0;
      valid_ff <= 1'b0;
      busy_ff <= 1'b0;
      div_err_ff <= 1'b0;
      sat_ff <= 1'b0;
      div_start_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      div_start_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start_i) begin
            coef_ff <= coef_i;
            mode_ff <= mode_i;
            rawt_ff <= 32'(rawt_in);
            dt_ff <= 32'(rawt_in) - 32'(coef_i.temp_reference[13:0]);
            x_ff <= 32'(raw_c_i) - scm_pkg::HALF_SCALE;
            flags_ff <= '0;
            busy_ff <= 1'b1;
            state_ff <= S_TC1;
          end
        end
        S_TC1: begin
          odr_ff <= odr_n;
          gdr_ff <= gdr_n;
          tsq_ff <= scm_pkg::mulsh(rawt_ff, rawt_ff, 0);
          state_ff <= S_TC2;
        end
        S_TC2: begin
          num_ff <= num_n;
          den_ff <= den_n;
          num_neg_ff <= num_n[31];
          temp_ff <= temp_c;
          flags_ff.sat <= t_hi || t_lo;
          state_ff <= S_DIV;
          if (den_n <= 32'sh0) begin
            flags_ff.div_err <= 1'b1;
            state_ff <= S_SUM;
          end else begin
            div_start_ff <= 1'b1;
          end
        end
        S_DIV: begin
          if (div_done) begin
            temp_corrected_raw_ff <= rtc_c;
            flags_ff.sat <= flags_ff.sat || rtc_hi || rtc_lo || q_big;
            state_ff <= S_SPLIT;
          end
        end
        S_SPLIT: begin
          r1_ff <= r1_n;
          r2_ff <= r2_n;
          state_ff <= S_GAIN;
        end
        S_GAIN: begin
          u1_ff <= scm_pkg::mulsh(k_g1, r1_ff, scm_pkg::GAIN_SH);
          u2_ff <= scm_pkg::mulsh(k_g2, r2_ff, scm_pkg::GAIN_SH);
          state_ff <= S_SQ;
        end
        S_SQ: begin
          sq1_ff <= scm_pkg::mulsh(u1_ff, u1_ff, scm_pkg::SQ_SH);
          sq2_ff <= scm_pkg::mulsh(u2_ff, u2_ff, scm_pkg::SQ_SH);
          state_ff <= S_CUBE;
        end
        S_CUBE: begin
          cube_ff <= scm_pkg::mulsh(sq1_ff, u1_ff, scm_pkg::SQ_SH);
          state_ff <= S_SUM;
        end
        S_SUM: begin
          cap_ff <= flags_ff.div_err ? 16'h0000 : out_c;
          div_err_ff <= flags_ff.div_err;
          sat_ff <= flags_ff.sat || (!flags_ff.div_err && (out_hi || out_lo));
          valid_ff <= 1'b1;
          busy_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // shared divider for the drift denominator
  scm_divider u_div (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .start_i    (div_start_ff),
    .dividend_i (dvd),
    .divisor_i  (32'(den_ff)),
    .done_o     (div_done),
    .quotient_o (div_q)
  );

  assign cap_o     = cap_ff;
  assign temp_o    = temp_ff;
  assign valid_o   = valid_ff;
  assign busy_o    = busy_ff;
  assign div_err_o = div_err_ff;
  assign sat_o     = sat_ff;

endmodule // scm_core

// ===== sim/scm_core_sva.sv
// Purpose: concurrent checks on the correction datapath ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   helper registers capture zero-gain and flat-temperature facts and the temperature offset at each take
`timescale 1ns/1ns
module scm_core_sva (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_b_i,
  // request
  input  wire logic               start_i,
  input  wire scm_pkg::scm_coef_t coef_i,
  // results
  input  wire logic [15:0]        cap_o,
  input  wire logic [15:0]        temp_o,
  input  wire logic               valid_o,
  input  wire logic               busy_o,
  input  wire logic               div_err_o,
  input  wire logic               sat_o
);
  logic        take_w;
  logic        zero_gain_ff;
  logic        flat_temp_ff;
  logic [15:0] temp_off_ff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // a request is taken only while idle
  assign take_w = start_i && !busy_o;

  // remember what the running request should give in simple cases
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_gain_ff <= 1'b0;
      flat_temp_ff <= 1'b0;
      temp_off_ff  <= 16'h0000;
    end else if (take_w) begin
      zero_gain_ff <= (coef_i.gain_one == 16'h0000) && (coef_i.gain_two == 16'h0000);
      flat_temp_ff <= (coef_i.temperature_gain == 16'h0000)
                      && (coef_i.temperature_quadratic_coef == 16'h0000);
      temp_off_ff  <= coef_i.temperature_offset;
    end
  end

  // handshake and result timing
  property p_take_answer; take_w |-> ##[1:60] valid_o; endproperty
  a_take_answer: assert property (p_take_answer) else $error("no result after take");
  property p_busy_holds; busy_o && !valid_o |=> busy_o || valid_o; endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");
  property p_valid_pulse; valid_o |=> !valid_o; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
  property p_idle_at_valid; valid_o |-> !busy_o; endproperty
  a_idle_at_valid: assert property (p_idle_at_valid) else $error("busy with valid");
  property p_busy_cause; $rose(busy_o) |-> $past(start_i); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_valid_cause; valid_o |-> $past(busy_o); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid while idle");
  // cap and flags only move with valid; temp settles early in a run
  property p_results_hold;
    !valid_o |-> $stable(cap_o) && $stable(div_err_o) && $stable(sat_o);
  endproperty
  a_results_hold: assert property (p_results_hold) else $error("result moved");
  property p_temp_settled; busy_o && $past(busy_o, 3) |-> $stable(temp_o); endproperty
  a_temp_settled: assert property (p_temp_settled) else $error("temp moved late");
  // value relations
  property p_zero_gain; valid_o && zero_gain_ff && !div_err_o |-> cap_o == 16'h0000; endproperty
  a_zero_gain: assert property (p_zero_gain) else $error("zero gain gave nonzero");
  property p_flat_temp; valid_o && flat_temp_ff |-> temp_o == temp_off_ff; endproperty
  a_flat_temp: assert property (p_flat_temp) else $error("temp not offset");
endmodule // scm_core_sva

// ===== sim/scm_afe_model.sv
// Purpose: front-end converter stand-in presenting raw readings
// Assumes: load_i is a one-cycle request to present a new conversion
// Notes:   bits above the chosen resolution carry junk that toggles
`timescale 1ns/1ns
module scm_afe_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // conversion to present
  input  wire logic        load_i,
  input  wire logic [15:0] cap_code_i,
  input  wire logic [13:0] temp_code_i,
  input  wire logic [1:0]  res_i,
  // raw readings
  output logic [15:0]      raw_c_o,
  output logic [13:0]      raw_t_o
);
  logic [13:0] temp_ff;
  logic [13:0] junk_ff;
  logic [13:0] keep_mask;

  // short conversions leave upper bits undriven, so they never read as zero
  assign keep_mask = 14'h3FFF >> (4'h6 - {1'b0, res_i, 1'b0});
  assign raw_t_o   = (temp_ff & keep_mask) | (junk_ff & ~keep_mask);

  // latch a conversion on request, junk flips every cycle
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw_c_o <= 16'h0000;
      temp_ff <= 14'h0000;
      junk_ff <= 14'h2AAA;
    end else begin
      junk_ff <= ~junk_ff;
      if (load_i) begin
        raw_c_o <= cap_code_i;
        temp_ff <= temp_code_i;
      end
    end
  end
endmodule // scm_afe_model

// ===== sim/tb.sv
// Purpose: self-checking bench of the correction datapath
// Assumes: fixed-point scaling as set by the package
// Notes:   rows tweak up to two coefficient fields of a unity set
`timescale 1ns/1ns
`define SCM_CHK(nm, e, g) \
  samples_checked++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end
module tb;
  typedef struct packed {
    logic [15:0] rc; logic [13:0] rt; logic [1:0] res; logic md;
    logic [3:0] k1; logic [15:0] v1; logic [3:0] k2; logic [15:0] v2;
    logic [15:0] ecap; logic [15:0] etemp; logic esat;
  } scm_tb_row_t;
  localparam scm_pkg::scm_coef_t BASE = '{16'h0000, 16'h1000, 16'h1000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h4000, 16'h0000, 16'h0000};
  // raw C, raw T, res, mode, field/value twice, expected cap, temp, sat
  scm_tb_row_t rows [22] = '{
    '{16'h9000, 14'h0000, 2'h3, 1'h0, 4'hF, 16'h0000, 4'hF, 16'h0000, 16'h9000, 16'h0000, 1'h0},
    '{16'h9000, 14'h0000, 2'h3, 1'h0, 4'h0, 16'h0100, 4'hF, 16'h0000, 16'h9100, 16'h0000, 1'h0},
    '{16'hA000, 14'h0000, 2'h3, 1'h0, 4'hA, 16'h9000, 4'h2, 16'h2000, 16'hB000, 16'h0000, 1'h0},
    '{16'h8000, 14'h0000, 2'h3, 1'h0, 4'hA, 16'h9000, 4'h2, 16'h2000, 16'h8000, 16'h0000, 1'h0},
    '{16'h8000, 14'h0000, 2'h3, 1'h0, 4'h3, 16'h4000, 4'hF, 16'h0000, 16'hA000, 16'h0000, 1'h0},
    '{16'h8000, 14'h0000, 2'h3, 1'h1, 4'h4, 16'h4000, 4'hA, 16'h4000, 16'h9000, 16'h0000, 1'h0},
    '{16'hC000, 14'h0000, 2'h3, 1'h0, 4'h4, 16'h4000, 4'hA, 16'h8000, 16'hC800, 16'h0000, 1'h0},
    '{16'h8000, 14'h2000, 2'h3, 1'h0, 4'h5, 16'h4000, 4'hF, 16'h0000, 16'h9000, 16'h2000, 1'h0},
    '{16'h9200, 14'h2000, 2'h3, 1'h0, 4'h7, 16'h4000, 4'hF, 16'h0000, 16'h9000, 16'h2000, 1'h0},
    '{16'h9000, 14'h1000, 2'h3, 1'h0, 4'h9, 16'h3000, 4'h5, 16'h4000, 16'h8000, 16'h1000, 1'h0},
    '{16'h9000, 14'h2ABC, 2'h3, 1'h0, 4'h9, 16'h2ABC, 4'h7, 16'h4000, 16'h9000, 16'h2ABC, 1'h0},
    '{16'h8000, 14'h2000, 2'h3, 1'h0, 4'h6, 16'h4000, 4'hF, 16'h0000, 16'h8400, 16'h2000, 1'h0},
    '{16'h8000, 14'h00FF, 2'h0, 1'h0, 4'hF, 16'h0000, 4'hF, 16'h0000, 16'h8000, 16'h00FF, 1'h0},
    '{16'h8000, 14'h03FF, 2'h1, 1'h0, 4'hF, 16'h0000, 4'hF, 16'h0000, 16'h8000, 16'h03FF, 1'h0},
    '{16'h8000, 14'h0FFF, 2'h2, 1'h0, 4'hF, 16'h0000, 4'hF, 16'h0000, 16'h8000, 16'h0FFF, 1'h0},
    '{16'h8000, 14'h0100, 2'h3, 1'h0, 4'hC, 16'hFF00, 4'hF, 16'h0000, 16'h8000, 16'h0000, 1'h0},
    '{16'h8000, 14'h3FFF, 2'h3, 1'h0, 4'hD, 16'h1000, 4'hF, 16'h0000, 16'h8000, 16'h4FFE, 1'h0},
    '{16'h8000, 14'h3FFF, 2'h3, 1'h0, 4'hC, 16'h7FFF, 4'hF, 16'h0000, 16'h8000, 16'h7FFF, 1'h1},
    '{16'h8000, 14'h3FFF, 2'h3, 1'h0, 4'hB, 16'h8000, 4'hC, 16'h8000, 16'h8000, 16'h8000, 1'h1},
    '{16'h8000, 14'h0000, 2'h3, 1'h0, 4'h1, 16'h7FFF, 4'hF, 16'h0000, 16'hFFFF, 16'h0000, 1'h1},
    '{16'h9000, 14'h0000, 2'h3, 1'h0, 4'h1, 16'h0000, 4'h2, 16'h0000, 16'h0000, 16'h0000, 1'h0},
    '{16'h8000, 14'h3FFF, 2'h3, 1'h0, 4'hB, 16'h0000, 4'hC, 16'h1234, 16'h8000, 16'h1234, 1'h0}};
  int                 mismatches = 0;
  int                 samples_checked = 0;
  logic               clk_sys, rst_b, start, ld;
  logic [15:0]        cap_code, raw_c, cap, temp;
  logic [13:0]        temp_code, raw_t;
  logic [1:0]         res;
  logic               valid, busy, div_err, sat;
  scm_pkg::scm_mode_t mode;
  scm_pkg::scm_coef_t coef;

  scm_afe_model u_afe (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .load_i(ld), .cap_code_i(cap_code),
    .temp_code_i(temp_code), .res_i(res), .raw_c_o(raw_c), .raw_t_o(raw_t));
  scm_core dut (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .start_i(start), .raw_c_i(raw_c),
    .raw_t_i(raw_t), .mode_i(mode), .temp_res_i(res), .coef_i(coef), .cap_o(cap),
    .temp_o(temp), .valid_o(valid), .busy_o(busy), .div_err_o(div_err), .sat_o(sat));

  // verdict and end of run
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // present a conversion and coefficient set, leaving start alone
  task automatic load(input scm_tb_row_t r);
    scm_pkg::scm_coef_t c;
    c = BASE;
    if (r.k1 != 4'hF) c[16 * (13 - int'(r.k1)) +: 16] = r.v1;
    if (r.k2 != 4'hF) c[16 * (13 - int'(r.k2)) +: 16] = r.v2;
    @(posedge clk_sys);
    ld <= 1'b1;
    cap_code <= r.rc;
    temp_code <= r.rt;
    res <= r.res;
    mode <= scm_pkg::scm_mode_t'(r.md);
    coef <= c;
    @(posedge clk_sys);
    ld <= 1'b0;
  endtask

  // one request: start seen at a single edge
  task automatic go(input scm_tb_row_t r);
    load(r);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask

  // bounded wait for the result pulse, stopping mid-cycle inside it
  task automatic wait_valid();
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 70) begin
      @(negedge clk_sys);
      n++;
    end
    `SCM_CHK("valid", 1'b1, valid)
  endtask

  task automatic check(input scm_tb_row_t r);
    `SCM_CHK("cap", r.ecap, cap)
    `SCM_CHK("temp", r.etemp, temp)
    `SCM_CHK("sat", r.esat, sat)
    `SCM_CHK("div_err", 1'b0, div_err)
  endtask

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // about 26 runs of 60 cycles; far beyond that means a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {rst_b, start, ld, cap_code, temp_code, res} = '0;
    mode = scm_pkg::SCM_MODE_TWO_REGION;
    coef = BASE;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      go(rows[i]);
      wait_valid();
      check(rows[i]);
    end
    // mid-run reset clears cap, busy and sat
    go(rows[19]);
    wait_valid();
    check(rows[19]);
    go(rows[0]);
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b0;
    @(negedge clk_sys);
    `SCM_CHK("rst cap", 16'h0000, cap)
    `SCM_CHK("rst busy", 1'b0, busy)
    `SCM_CHK("rst sat", 1'b0, sat)
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    // start held through a run is refused, then taken in the valid cycle
    go(rows[1]);
    load(rows[18]);
    start <= 1'b1;
    wait_valid();
    check(rows[1]);
    @(posedge clk_sys);
    start <= 1'b0;
    @(negedge clk_sys);
    `SCM_CHK("back to back busy", 1'b1, busy)
    wait_valid();
    check(rows[18]);
    report_and_stop();
  end
endmodule // tb

bind scm_core scm_core_sva u_sva (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .start_i(start_i),
  .coef_i(coef_i), .cap_o(cap_o), .temp_o(temp_o), .valid_o(valid_o), .busy_o(busy_o),
  .div_err_o(div_err_o), .sat_o(sat_o));
